//--- shared/osp_consts.svh
// Behaviour
// [RULE1] Mode entry: 0 free run, 1 buffer event, 2 pulse first, 3 pulse second; resets 0
// [RULE2] Free run: cycle time entry is the local timer period in ns
// [RULE3] Buffer event mode: cycle time entry holds the master cycle time in ns
// [RULE4] Clock mode: cycle time entry is the pulse sequence period in ns
// [RULE5] Clock mode: outputs driven once shift time elapsed after pulse first
// [RULE6] Capability word read only, bit 0 free run, bit 1 buffer event, reset 0xc001
// [RULE7] Capability bits 3:2 equal 10 report distributed clock support
// [RULE8] Capability bits 5:4 equal 01 report output shift by pulse second
// [RULE9] Capability bit 14 reports timing entries measured via the command entry
// [RULE10] Read-only entry reports shortest sustainable cycle time in ns
// [RULE11] Read-only calc-and-copy entry gives least pulse spacing in ns
// [RULE12] Command write 1 starts cycle-time measurement, 0 stops it
// [RULE13] While measuring, shift, cycle, calc-copy and delay entries take maxima
// [RULE14] Starting a measurement clears earlier maxima first
// [RULE15] Clock mode: delay entry reports pulse second to output drive in ns
// [RULE16] Clock mode in run state: count missed buffer events, 16 bits
// [RULE17] Run state: count cycle overruns, 16 bits
// [RULE18] Clock mode: count pulse spacings shorter than required, 16 bits
// [RULE19] Clock mode: error flag set when last drive was late, else cleared
// [RULE20] Subindex 0 reads constant entry count 0x20
// [RULE21] Error counters saturate at maximum
// [RULE22] Writing an unsupported mode is rejected, mode kept
`ifndef OSP_CONSTS_SVH
`define OSP_CONSTS_SVH
`define OSP_SUB_COUNT      8'h00
`define OSP_SUB_MODE       8'h01
`define OSP_SUB_CYCLE      8'h02
`define OSP_SUB_SHIFT      8'h03
`define OSP_SUB_CAPS       8'h04
`define OSP_SUB_MIN_CYCLE  8'h05
`define OSP_SUB_CALC_COPY  8'h06
`define OSP_SUB_COMMAND    8'h08
`define OSP_SUB_DELAY      8'h09
`define OSP_SUB_MISSED     8'h0b
`define OSP_SUB_OVERRUN    8'h0c
`define OSP_SUB_SHORT      8'h0d
`define OSP_SUB_SYNC_ERR   8'h20
`define OSP_ENTRY_COUNT    8'h20
`define OSP_CAP_RESET      16'hc001
`define OSP_MODE_FREE      16'h0000
`define OSP_MODE_BUFFER    16'h0001
`define OSP_MODE_PULSE1    16'h0002
`define OSP_MODE_PULSE2    16'h0003
`define OSP_CAP_FREE_BIT   0
`define OSP_CAP_BUF_BIT    1
`define OSP_CAP_CLK_MSB    3
`define OSP_CAP_CLK_LSB    2
`define OSP_CAP_CLK_VAL    2'h2
`define OSP_CAP_SH_MSB     5
`define OSP_CAP_SH_LSB     4
`define OSP_CAP_SH_VAL     2'h1
`define OSP_CAP_DYN_BIT    14
`define OSP_CMD_STOP       16'h0000
`define OSP_CMD_START      16'h0001
`define OSP_CLK_PERIOD_NS  32'h0000_0004
`define OSP_CNT_MAX        16'hffff
`define OSP_NS_MAX         32'hffff_ffff
`endif

//--- shared/osp_pkg.sv
package osp_pkg;
  // Synchronised pin levels
  typedef struct packed {
    logic buf_evt;
    logic pulse_first;
    logic pulse_second;
    logic run;
  } osp_pins_type;

  // Object access request and answer
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  sub;
    logic [31:0] data;
  } osp_req_type;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] data;
  } osp_rsp_type;

  // Measured maxima
  typedef struct packed {
    logic [31:0] shift;
    logic [31:0] min_cycle;
    logic [31:0] calc_copy;
    logic [31:0] delay;
  } osp_meas_type;

  typedef enum logic [1:0] {PH_IDLE, PH_BUSY, PH_HOLD} osp_phase_type;

  typedef struct packed {
    osp_pins_type  clock_pulse_second;
    osp_pins_type  sync2;
    osp_pins_type  prev;
    logic [15:0]   mode;
    logic [31:0]   cycle_time;
    logic [31:0]   shift_time;
    logic [15:0]   command;
    osp_meas_type  meas;
    logic [15:0]   missed;
    logic [15:0]   overrun;
    logic [15:0]   short_cnt;
    logic          sync_err;
    logic [31:0]   timer_ns;
    logic [31:0]   since_p0;
    logic [31:0]   since_p1;
    logic [31:0]   since_trig;
    osp_phase_type phase;
    logic          due;
    logic          late;
    logic          buf_seen;
    logic          drive;
    osp_rsp_type   rsp;
  } osp_state_type;
endpackage : osp_pkg

//--- rtl/osp_output_sync.sv
`timescale 1ns/10ps
`include "osp_consts.svh"

module osp_output_sync #(
  parameter logic [15:0] SYNC_CAPS = `OSP_CAP_RESET
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // Sync pins from outside the clock domain
  input  wire osp_pkg::osp_pins_type PINS,
  // Application processing finished
  input  wire logic                  COPY_DONE,
  // Object access from the master mailbox
  input  wire osp_pkg::osp_req_type  OBJ_REQ,
  output      osp_pkg::osp_rsp_type  OBJ_RSP,
  // Output timing and status
  output      logic                  OUTPUT_DRIVE,
  output      logic                  SYNC_ERROR,
  output      logic                  MEASURE_ACTIVE,
  output      osp_pkg::osp_meas_type MEASURE_MAX
);

  // ==========================================================
  // Helper functions
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == `OSP_CNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  function automatic logic [31:0] add_ns(input logic [31:0] v);
    logic [32:0] sum;
    sum = {1'b0, v} + {1'b0, `OSP_CLK_PERIOD_NS};
    add_ns = sum[32] ? `OSP_NS_MAX : sum[31:0];
  endfunction : add_ns

  function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
    max32 = (a > b) ? a : b;
  endfunction : max32

  function automatic logic mode_supported(input logic [15:0] m, input logic [15:0] caps);
    unique case (m)
      `OSP_MODE_FREE:   mode_supported = caps[`OSP_CAP_FREE_BIT];
      `OSP_MODE_BUFFER: mode_supported = caps[`OSP_CAP_BUF_BIT];
      `OSP_MODE_PULSE1: mode_supported = caps[`OSP_CAP_CLK_MSB:`OSP_CAP_CLK_LSB] == `OSP_CAP_CLK_VAL;
      `OSP_MODE_PULSE2: mode_supported = (caps[`OSP_CAP_CLK_MSB:`OSP_CAP_CLK_LSB] == `OSP_CAP_CLK_VAL)
                                         && (caps[`OSP_CAP_SH_MSB:`OSP_CAP_SH_LSB] == `OSP_CAP_SH_VAL);
      default:          mode_supported = 1'b0;
    endcase
  endfunction : mode_supported

  // ==========================================================
  // State
  osp_pkg::osp_state_type state;
  osp_pkg::osp_state_type next_state;

  logic buf_rise;
  logic p0_rise;
  logic p1_rise;
  logic run;
  logic dist_mode;
  logic tick;
  logic trigger;

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    next_state.clock_pulse_second = PINS;
    next_state.sync2 = state.clock_pulse_second;
    next_state.prev  = state.sync2;
    next_state.drive = 1'b0;
    next_state.rsp   = '0;

    buf_rise = state.sync2.buf_evt & ~state.prev.buf_evt;
    p0_rise  = state.sync2.pulse_first & ~state.prev.pulse_first;
    p1_rise  = state.sync2.pulse_second & ~state.prev.pulse_second;
    run      = state.sync2.run;
    dist_mode = (state.mode == `OSP_MODE_PULSE1) || (state.mode == `OSP_MODE_PULSE2);

    // Elapsed times since pulses and cycle start
    next_state.since_p0   = p0_rise ? 32'h0000_0000 : add_ns(state.since_p0);
    next_state.since_p1   = p1_rise ? 32'h0000_0000 : add_ns(state.since_p1);
    next_state.since_trig = add_ns(state.since_trig);

    // Local timer paced by cycle time
    tick = 1'b0;
    if (state.mode == `OSP_MODE_FREE && state.cycle_time != 32'h0000_0000) begin
      if (add_ns(state.timer_ns) >= state.cycle_time) begin // [RULE2]
        tick = 1'b1;
        next_state.timer_ns = 32'h0000_0000;
      end else begin
        next_state.timer_ns = add_ns(state.timer_ns);
      end
    end else begin
      next_state.timer_ns = 32'h0000_0000;
    end

    // Cycle start per mode
    unique case (state.mode)
      `OSP_MODE_FREE:   trigger = tick;                      // [RULE1]
      `OSP_MODE_BUFFER: trigger = buf_rise;                  // [RULE1] [RULE3]
      `OSP_MODE_PULSE1: trigger = p0_rise;                   // [RULE1] [RULE4]
      `OSP_MODE_PULSE2: trigger = p0_rise;                   // [RULE1] [RULE4]
      default:          trigger = 1'b0;
    endcase

    // Missed buffer events, checked at each pulse first
    if (p0_rise) begin
      if (dist_mode && run && !state.buf_seen) begin
        next_state.missed = sat_inc(state.missed);           // [RULE16] [RULE21]
      end
      next_state.buf_seen = 1'b0;
    end
    if (buf_rise) begin
      next_state.buf_seen = 1'b1;
    end

    // Pulse spacing too short
    if (dist_mode && p1_rise && state.since_p0 < state.meas.calc_copy) begin
      next_state.short_cnt = sat_inc(state.short_cnt);       // [RULE18] [RULE11] [RULE21]
    end

    // Output schedule
    if (state.phase != osp_pkg::PH_IDLE && !state.due) begin
      if (state.mode == `OSP_MODE_PULSE1 && state.since_p0 >= state.shift_time) begin
        next_state.due = 1'b1;                               // [RULE5]
      end
      if (state.mode == `OSP_MODE_PULSE2 && p1_rise) begin
        next_state.due = 1'b1;                               // [RULE8]
      end
    end
    if (state.phase == osp_pkg::PH_BUSY && state.due) begin
      next_state.late = 1'b1;
    end

    // Processing finished
    if (state.phase == osp_pkg::PH_BUSY && COPY_DONE) begin
      next_state.phase = osp_pkg::PH_HOLD;
      if (state.command == `OSP_CMD_START) begin
        next_state.meas.calc_copy = max32(state.meas.calc_copy, state.since_trig); // [RULE13] [RULE11]
        if (dist_mode) begin
          next_state.meas.shift = max32(state.meas.shift, state.since_p0);         // [RULE13]
          if (state.since_p0 > state.meas.shift) begin
            next_state.shift_time = state.since_p0;                                 // [RULE13]
          end
        end
      end
    end

    // Drive outputs once ready and due
    if (state.phase == osp_pkg::PH_HOLD && state.due) begin
      next_state.drive = 1'b1;
      next_state.phase = osp_pkg::PH_IDLE;
      next_state.due   = 1'b0;
      next_state.sync_err = dist_mode & state.late;          // [RULE19]
      if (state.command == `OSP_CMD_START) begin
        next_state.meas.min_cycle = max32(state.meas.min_cycle, state.since_trig); // [RULE10] [RULE13]
        if (dist_mode) begin
          next_state.meas.delay = max32(state.meas.delay, state.since_p1);         // [RULE15] [RULE13]
        end
      end
    end

    // New cycle start
    if (trigger) begin
      if (run && state.phase != osp_pkg::PH_IDLE) begin
        next_state.overrun = sat_inc(state.overrun);         // [RULE17] [RULE21]
      end
      next_state.phase      = osp_pkg::PH_BUSY;
      next_state.since_trig = 32'h0000_0000;
      next_state.due        = !dist_mode;
      next_state.late       = 1'b0;
    end

    // Object access, write before read
    if (OBJ_REQ.wr) begin
      next_state.rsp.ack = 1'b1;
      unique case (OBJ_REQ.sub)
        `OSP_SUB_MODE: begin
          if (mode_supported(OBJ_REQ.data[15:0], SYNC_CAPS)) begin
            next_state.mode = OBJ_REQ.data[15:0];            // [RULE1]
          end else begin
            next_state.rsp.abort = 1'b1;                     // [RULE22]
          end
        end
        `OSP_SUB_CYCLE: next_state.cycle_time = OBJ_REQ.data;
        `OSP_SUB_SHIFT: next_state.shift_time = OBJ_REQ.data;
        `OSP_SUB_COMMAND: begin
          if (OBJ_REQ.data[15:0] == `OSP_CMD_START) begin
            next_state.command = `OSP_CMD_START;             // [RULE12]
            next_state.meas    = '0;                         // [RULE14]
          end else if (OBJ_REQ.data[15:0] == `OSP_CMD_STOP) begin
            next_state.command = `OSP_CMD_STOP;              // [RULE12]
          end else begin
            next_state.rsp.abort = 1'b1;
          end
        end
        default: next_state.rsp.abort = 1'b1;
      endcase
    end else if (OBJ_REQ.rd) begin
      next_state.rsp.ack = 1'b1;
      unique case (OBJ_REQ.sub)
        `OSP_SUB_COUNT:     next_state.rsp.data = {24'h000000, `OSP_ENTRY_COUNT}; // [RULE20]
        `OSP_SUB_MODE:      next_state.rsp.data = {16'h0000, state.mode};
        `OSP_SUB_CYCLE:     next_state.rsp.data = state.cycle_time;
        `OSP_SUB_SHIFT:     next_state.rsp.data = state.shift_time;
        `OSP_SUB_CAPS:      next_state.rsp.data = {16'h0000, SYNC_CAPS}; // [RULE6] [RULE7] [RULE8] [RULE9]
        `OSP_SUB_MIN_CYCLE: next_state.rsp.data = state.meas.min_cycle;  // [RULE10]
        `OSP_SUB_CALC_COPY: next_state.rsp.data = state.meas.calc_copy;  // [RULE11]
        `OSP_SUB_COMMAND:   next_state.rsp.data = {16'h0000, state.command};
        `OSP_SUB_DELAY:     next_state.rsp.data = state.meas.delay;      // [RULE15]
        `OSP_SUB_MISSED:    next_state.rsp.data = {16'h0000, state.missed};
        `OSP_SUB_OVERRUN:   next_state.rsp.data = {16'h0000, state.overrun};
        `OSP_SUB_SHORT:     next_state.rsp.data = {16'h0000, state.short_cnt};
        `OSP_SUB_SYNC_ERR:  next_state.rsp.data = {31'h00000000, state.sync_err};
        default:            next_state.rsp.abort = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign OBJ_RSP        = state.rsp;
  assign OUTPUT_DRIVE   = state.drive;
  assign SYNC_ERROR     = state.sync_err;
  assign MEASURE_ACTIVE = (state.command == `OSP_CMD_START);
  assign MEASURE_MAX    = state.meas;

endmodule : osp_output_sync

//--- testbench/osp_output_sync_assertions.sv
`timescale 1ns/10ps
// ==========
// Port checker
module osp_output_sync_assertions #(
  parameter logic [15:0] SYNC_CAPS = 16'hc001
) (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  RESET,
  // Object access
  input wire osp_pkg::osp_req_type  OBJ_REQ,
  input wire osp_pkg::osp_rsp_type  OBJ_RSP,
  // Timing and status
  input wire logic                  OUTPUT_DRIVE,
  input wire logic                  MEASURE_ACTIVE,
  input wire osp_pkg::osp_meas_type MEASURE_MAX
);
  logic cmd_wr;
  logic mode_wr;
  logic ro_sub;
  assign cmd_wr  = OBJ_REQ.wr && (OBJ_REQ.sub == 8'h08);
  assign mode_wr = OBJ_REQ.wr && (OBJ_REQ.sub == 8'h01);
  assign ro_sub  = OBJ_REQ.sub inside {8'h00, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_start;
    cmd_wr && (OBJ_REQ.data[15:0] == 16'h0001);
  endsequence
  sequence s_cleared;
    MEASURE_ACTIVE && (MEASURE_MAX == '0);
  endsequence
  a_obj_answer: assert property ((OBJ_REQ.wr || OBJ_REQ.rd) |=> OBJ_RSP.ack)
    else $error("object request not answered");
  a_count_const: assert property (OBJ_REQ.rd && !OBJ_REQ.wr && OBJ_REQ.sub == 8'h00
    |=> OBJ_RSP.data == 32'h20 && !OBJ_RSP.abort) else $error("entry count wrong");
  a_caps_value: assert property (OBJ_REQ.rd && !OBJ_REQ.wr && OBJ_REQ.sub == 8'h04
    |=> OBJ_RSP.data == {16'h0, SYNC_CAPS}) else $error("capability word wrong");
  a_ro_refuse: assert property (OBJ_REQ.wr && ro_sub |=> OBJ_RSP.ack && OBJ_RSP.abort)
    else $error("read-only write accepted");
  a_mode_range: assert property (mode_wr && OBJ_REQ.data[15:0] > 16'h3 |=> OBJ_RSP.abort)
    else $error("bad mode accepted");
  a_mode_reject: assert property (mode_wr && OBJ_REQ.data[15:0] == 16'h1 && !SYNC_CAPS[1]
    |=> OBJ_RSP.abort) else $error("unsupported mode accepted");
  a_meas_start: assert property (s_start |=> s_cleared)
    else $error("start did not clear maxima");
  a_meas_stop: assert property (cmd_wr && OBJ_REQ.data[15:0] == 16'h0 |=> !MEASURE_ACTIVE)
    else $error("stop ignored");
  a_meas_frozen: assert property (!MEASURE_ACTIVE && !cmd_wr |=> $stable(MEASURE_MAX))
    else $error("maxima moved while idle");
  a_meas_grow: assert property (MEASURE_ACTIVE && !cmd_wr
    |=> MEASURE_MAX.min_cycle >= $past(MEASURE_MAX.min_cycle)) else $error("maximum fell");
  a_drive_single: assert property (OUTPUT_DRIVE |=> !OUTPUT_DRIVE)
    else $error("drive pulse too long");
endmodule : osp_output_sync_assertions

bind osp_output_sync osp_output_sync_assertions #(.SYNC_CAPS(SYNC_CAPS)) chk_u (
  .CLK(CLK), .RESET(RESET), .OBJ_REQ(OBJ_REQ), .OBJ_RSP(OBJ_RSP),
  .OUTPUT_DRIVE(OUTPUT_DRIVE), .MEASURE_ACTIVE(MEASURE_ACTIVE), .MEASURE_MAX(MEASURE_MAX));

//--- testbench/osp_master_model.sv
`timescale 1ns/10ps
// ==========
// Mailbox master and sync pin source
module osp_master_model (
  // Clock
  input  wire logic                 clk,
  // Object access
  output osp_pkg::osp_req_type      obj_req,
  input  wire osp_pkg::osp_rsp_type obj_rsp,
  // Sync pins
  output osp_pkg::osp_pins_type     pins
);
  initial begin
    obj_req = '0;
    pins    = '0;
  end
  // One-cycle request, answer taken one edge later
  task automatic access(input logic w, input logic [7:0] s, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] st);
    @(posedge clk);
    #1 obj_req = '{rd: !w, wr: w, sub: s, data: d};
    @(posedge clk);
    #1 obj_req = '{rd: 1'b0, wr: 1'b0, sub: ~s, data: ~d};
    q  = obj_rsp.data;
    st = {obj_rsp.ack, obj_rsp.abort};
  endtask : access
  // Event pin held for three edges
  task automatic pulse(input int k);
    @(posedge clk);
    #1 pins[k] = 1'b1;
    repeat (3) @(posedge clk);
    #1 pins[k] = 1'b0;
  endtask : pulse
  task automatic set_run(input logic v);
    @(posedge clk);
    #1 pins.run = v;
  endtask : set_run
endmodule : osp_master_model

//--- testbench/output_sync_parameters_tb.sv
`timescale 1ns/10ps
// ==========
// Bench top
module output_sync_parameters_tb;
  logic                  clk;
  logic                  reset;
  logic                  copy_done;
  osp_pkg::osp_pins_type pins;
  osp_pkg::osp_req_type  req;
  osp_pkg::osp_rsp_type  rsp;
  osp_pkg::osp_rsp_type  rsp2;
  logic                  drive;
  logic                  meas_act;
  osp_pkg::osp_meas_type meas_max;
  logic                  sync_err;
  logic                  ref_drive;
  logic                  ref_err;
  logic                  ref_act;
  osp_pkg::osp_meas_type ref_max;
  int                    ref_cnt = 0;
  int                    error_cnt = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  int                    drv_cnt = 0;
  int                    n;
  logic [31:0]           q;
  logic [1:0]            st;
  logic [31:0]           base;
  logic [7:0]            subs [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                       8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20};
  osp_output_sync #(.SYNC_CAPS(16'hc01b)) dut_u (.CLK(clk), .RESET(reset), .PINS(pins),
    .COPY_DONE(copy_done), .OBJ_REQ(req), .OBJ_RSP(rsp), .OUTPUT_DRIVE(drive),
    .SYNC_ERROR(sync_err), .MEASURE_ACTIVE(meas_act), .MEASURE_MAX(meas_max));
  osp_output_sync ref_u (.CLK(clk), .RESET(reset), .PINS(pins), .COPY_DONE(copy_done),
    .OBJ_REQ(req), .OBJ_RSP(rsp2), .OUTPUT_DRIVE(ref_drive), .SYNC_ERROR(ref_err),
    .MEASURE_ACTIVE(ref_act), .MEASURE_MAX(ref_max));
  osp_master_model mst_u (.clk(clk), .obj_req(req), .obj_rsp(rsp), .pins(pins));
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic obj(input logic w, input logic [7:0] s, input logic [31:0] d,
                     input logic [31:0] e, input logic ea);
    mst_u.access(w, s, d, q, st);
    check({st, q}, {1'b1, ea, e});
  endtask : obj
  task automatic wait_drive;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (drive !== 1'b1 && n < 200);
  endtask : wait_drive
  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (drive === 1'b1) drv_cnt <= drv_cnt + 1;
    if (ref_drive === 1'b1) ref_cnt <= ref_cnt + 1;
    if (cyc == 4000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    copy_done = 1'b0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 13; i++) obj(1'b0, subs[i], 0, (i == 0) ? 32'h20 : (i == 4) ? 32'hc01b : 0, 1'b0);
    obj(1'b1, 8'h04, 32'h1, 0, 1'b1);
    obj(1'b0, 8'h04, 0, 32'hc01b, 1'b0);
    check(34'(rsp2.data), 34'hc001);
    obj(1'b0, 8'h07, 0, 0, 1'b1);
    obj(1'b1, 8'h02, 32'd40, 0, 1'b0);
    obj(1'b0, 8'h02, 0, 32'd40, 1'b0);
    for (int m = 0; m < 4; m++) begin
      obj(1'b1, 8'h01, m, 0, 1'b0);
      obj(1'b0, 8'h01, 0, m, 1'b0);
    end
    obj(1'b1, 8'h01, 32'h4, 0, 1'b1);
    obj(1'b0, 8'h01, 0, 32'h3, 1'b0);
    obj(1'b1, 8'h01, 32'h1, 0, 1'b0);
    check(34'(rsp2.abort), 34'h1);
    obj(1'b1, 8'h08, 32'h2, 0, 1'b1);
    obj(1'b1, 8'h01, 32'h0, 0, 1'b0);
    copy_done = 1'b1;
    wait_drive();
    wait_drive();
    check(34'(n), 34'd10);
    obj(1'b1, 8'h01, 32'h1, 0, 1'b0);
    repeat (12) @(posedge clk);
    obj(1'b1, 8'h08, 32'h1, 0, 1'b0);
    base = drv_cnt;
    repeat (3) begin
      mst_u.pulse(3);
      repeat (10) @(posedge clk);
    end
    check(34'(drv_cnt - base), 34'd3);
    check(34'(meas_max.min_cycle != 0), 34'h1);
    mst_u.access(1'b0, 8'h05, 0, q, st);
    check(34'(q != 0), 34'h1);
    obj(1'b1, 8'h08, 32'h0, 0, 1'b0);
    obj(1'b1, 8'h08, 32'h1, 0, 1'b0);
    check(34'(|meas_max), 34'h0);
    obj(1'b0, 8'h05, 0, 0, 1'b0);
    mst_u.set_run(1'b1);
    copy_done = 1'b0;
    mst_u.access(1'b0, 8'h0c, 0, base, st);
    mst_u.pulse(3);
    mst_u.pulse(3);
    repeat (4) @(posedge clk);
    #1 copy_done = 1'b1;
    obj(1'b0, 8'h0c, 0, base + 1, 1'b0);
    obj(1'b1, 8'h03, 32'd80, 0, 1'b0);
    obj(1'b1, 8'h01, 32'h2, 0, 1'b0);
    mst_u.pulse(2);
    wait_drive();
    check(34'(n >= 18 && n <= 26), 34'h1);
    mst_u.pulse(3);
    mst_u.pulse(2);
    repeat (30) @(posedge clk);
    mst_u.access(1'b0, 8'h0b, 0, base, st);
    mst_u.pulse(2);
    repeat (30) @(posedge clk);
    obj(1'b0, 8'h0b, 0, base + 1, 1'b0);
    obj(1'b1, 8'h01, 32'h3, 0, 1'b0);
    copy_done = 1'b0;
    mst_u.pulse(2);
    mst_u.pulse(1);
    repeat (4) @(posedge clk);
    #1 copy_done = 1'b1;
    wait_drive();
    check(34'(sync_err), 34'h1);
    obj(1'b0, 8'h20, 0, 32'h1, 1'b0);
    obj(1'b0, 8'h0d, 0, 32'h1, 1'b0);
    mst_u.pulse(2);
    repeat (10) @(posedge clk);
    mst_u.pulse(1);
    wait_drive();
    check(34'(sync_err), 34'h0);
    obj(1'b0, 8'h0d, 0, 32'h1, 1'b0);
    check({ref_err, ref_act, ref_max.delay}, {2'b01, 32'h0});
    check(34'(ref_cnt > 0), 34'h1);
    conclude();
  end
endmodule : output_sync_parameters_tb
